// >>> logic/fscd_top.sv
// Function
// - Fault bit 7 reserved: reads zero, writes to it ignored.
// - Fault bit 6, forced-off flag, unsupported, always reads zero.
// - Auto discharge enabled and vbus not safe within window latches bit 5.
// - Forced discharge and vbus not safe within window latches bit 4.
// - Bus overcurrent bit 3 and overvoltage bit 2 always read zero.
// - Cable supply overcurrent latches fault bit 1.
// - Cable supply low while its switch is closed also latches bit 1.
// - Transmit with empty buffer latches host error bit 0.
// - Wake command accepted and changes nothing.
// - Code 0x22 turns presence monitoring off.
// - Code 0x33 turns presence monitoring on.
// - Presence-monitor status bit follows the detect enable state.
// - Code 0x44 clears the sinking status bit.
// - Code 0x55 with sink capability sets sinking and enables monitoring.
// - Code 0x66 clears sourcing and sourcing-high-voltage status bits.
// - Command register at 0x23, resets to 0x00.
module fscd_top #(
	parameter int DISCHARGE_CYCLES = fscd_pkg::DISCHARGE_CYCLES
) (
	// clock and reset
	input  wire logic                clock,
	input  wire logic                arst_n,
	// register access from the port manager
	input  wire fscd_pkg::fscd_reg_req_t reg_req,
	output logic [7:0]               reg_rdata,
	// discharge supervision
	input  wire logic                discharge_on_detach,
	input  wire logic                forced_discharge,
	input  wire logic                detach_event,
	input  wire logic                safe_zero_level,
	// cable supply supervision
	input  wire logic                cable_overcurrent,
	input  wire logic                cable_switch_closed,
	input  wire logic                cable_below_present,
	// transmit path
	input  wire logic                tx_request,
	input  wire logic                tx_buffer_empty,
	// capability and source status from the rest of the controller
	input  wire logic                sink_capable,
	input  wire logic                sourcing_set,
	input  wire logic                sourcing_hv_set,
	// power status
	output fscd_pkg::fscd_pwr_t      pwr_status,
	// raw fault flags
	output logic [7:0]               fault_flags
);
	import fscd_pkg::*;

	// ****************************************************************
	// reset release
	// ****************************************************************

	logic rst_meta;
	logic rst_n;

	// assert at once, release two edges later
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ****************************************************************
	// state
	// ****************************************************************

	typedef struct packed {
		logic [7:0] command;
		logic [7:0] fault;
		fscd_pwr_t  pwr;
		logic       forced_q;
		logic [7:0] rdata;
	} fscd_state_t;

	fscd_state_t   st;
	fscd_state_t   next_st;
	fscd_cmd_act_t act;
	logic          auto_fail;
	logic          forced_fail;
	logic          cmd_write;
	logic          fault_write;
	logic          fault_read;
	logic [7:0]    fault_set;
	logic [7:0]    fault_clear;
	logic [7:0]    fault_view;

	// ****************************************************************
	// address decode
	// ****************************************************************

	// strobes qualified by address
	always_comb begin
		cmd_write   = 1'b0;
		fault_write = 1'b0;
		fault_read  = 1'b0;
		if (reg_req.addr == CMD_OFS) begin
			cmd_write = reg_req.wr;
		end else if (reg_req.addr == FAULT_OFS) begin
			fault_write = reg_req.wr;
			fault_read  = reg_req.rd;
		end
	end

	// ****************************************************************
	// submodules
	// ****************************************************************

	fscd_cmd_decode u_decode (
		.cmd_write (cmd_write),
		.cmd_code  (reg_req.wdata),
		.act       (act)
	);

	// auto window opens on detach only while auto discharge is enabled
	fscd_discharge_timer #(.CYCLES(DISCHARGE_CYCLES)) u_auto_tmr (
		.clock      (clock),
		.rst_n      (rst_n),
		.start      (detach_event && discharge_on_detach),
		.active     (discharge_on_detach),
		.below_safe (safe_zero_level),
		.fail       (auto_fail)
	);

	// forced window opens on the rising edge of the request
	fscd_discharge_timer #(.CYCLES(DISCHARGE_CYCLES)) u_forced_tmr (
		.clock      (clock),
		.rst_n      (rst_n),
		.start      (forced_discharge && !st.forced_q),
		.active     (forced_discharge),
		.below_safe (safe_zero_level),
		.fail       (forced_fail)
	);

	// ****************************************************************
	// fault flags
	// ****************************************************************

	// events that set flags this cycle
	always_comb begin
		fault_set = '0;
		fault_set[FLT_AUTO_DIS_BIT]  = auto_fail;
		fault_set[FLT_FORCE_DIS_BIT] = forced_fail;
		fault_set[FLT_CABLE_BIT]     = cable_overcurrent
			|| (cable_switch_closed && cable_below_present);
		fault_set[FLT_HOST_ERR_BIT]  = tx_request && tx_buffer_empty;
	end

	// write one clears; reserved and unsupported bits are masked off
	assign fault_clear = fault_write ? (reg_req.wdata & FAULT_LIVE_MASK) : 8'h00;

	// unsupported flags read as zero
	assign fault_view = st.fault & FAULT_LIVE_MASK;

	// ****************************************************************
	// next state
	// ****************************************************************

	// one next-state process for all registers of the block except the reset synchronizer
	always_comb begin
		next_st = st;
		next_st.forced_q = forced_discharge;

		// command register keeps last code; it is write only
		if (cmd_write) begin
			next_st.command = reg_req.wdata;
		end

		// a set in the clearing cycle wins over the clear
		next_st.fault = ((st.fault & ~fault_clear) | fault_set) & FAULT_LIVE_MASK;

		// command effects on power status
		if (act.detect_off) begin
			next_st.pwr.presence_monitor_on = 1'b0;
		end
		if (act.detect_on) begin
			next_st.pwr.presence_monitor_on = 1'b1;
		end
		if (act.sink_off) begin
			next_st.pwr.sinking_vbus = 1'b0;
		end
		if (act.sink_on && sink_capable) begin
			next_st.pwr.sinking_vbus        = 1'b1;
			next_st.pwr.presence_monitor_on = 1'b1;
		end

		// source status is set elsewhere; the command takes precedence
		if (sourcing_set) begin
			next_st.pwr.sourcing_vbus = 1'b1;
		end
		if (sourcing_hv_set) begin
			next_st.pwr.sourcing_high_voltage = 1'b1;
		end
		if (act.source_off) begin
			next_st.pwr.sourcing_vbus         = 1'b0;
			next_st.pwr.sourcing_high_voltage = 1'b0;
		end

		// read data: only the fault register is readable here
		if (fault_read) begin
			next_st.rdata = fault_view;
		end else if (reg_req.rd) begin
			next_st.rdata = 8'h00; // command is write only, others unmapped
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st.command  <= CMD_RESET;
			st.fault    <= FAULT_RESET;
			st.pwr      <= '0;
			st.forced_q <= 1'b0;
			st.rdata    <= 8'h00;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flip-flops
	assign reg_rdata   = st.rdata;
	assign pwr_status  = st.pwr;
	assign fault_flags = st.fault;

	// ****************************************************************
	// checks
	// ****************************************************************

	default clocking fscd_cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_cmd(logic [7:0] code);
		reg_req.wr && reg_req.addr == CMD_OFS && reg_req.wdata == code;
	endsequence

	sequence s_fault_rd;
		reg_req.rd && reg_req.addr == FAULT_OFS;
	endsequence

	a_unsup_bits_zero: assert property (s_fault_rd |=>
		reg_rdata[7:6] == 2'h0 && reg_rdata[3:2] == 2'h0)
		else $error("reserved or unsupported fault bit read as one");

	a_read_matches: assert property (s_fault_rd |=>
		reg_rdata == ($past(fault_flags) & FAULT_LIVE_MASK))
		else $error("fault read data differs from flags");

	a_auto_latch: assert property (auto_fail |=> fault_flags[FLT_AUTO_DIS_BIT])
		else $error("auto discharge failure not latched");

	a_forced_latch: assert property (forced_fail |=> fault_flags[FLT_FORCE_DIS_BIT])
		else $error("forced discharge failure not latched");

	a_cable_ocp: assert property (cable_overcurrent |=> fault_flags[FLT_CABLE_BIT])
		else $error("cable overcurrent not latched");

	a_cable_low: assert property (
		cable_switch_closed && cable_below_present |=> fault_flags[FLT_CABLE_BIT])
		else $error("cable undervoltage not latched");

	a_host_error: assert property (
		tx_request && tx_buffer_empty |=> fault_flags[FLT_HOST_ERR_BIT])
		else $error("empty transmit not flagged");

	a_flag_clear: assert property (
		reg_req.wr && reg_req.addr == FAULT_OFS && reg_req.wdata[FLT_HOST_ERR_BIT]
		&& !(tx_request && tx_buffer_empty) |=> !fault_flags[FLT_HOST_ERR_BIT])
		else $error("write one did not clear flag");

	a_flag_hold: assert property (
		fault_flags[FLT_CABLE_BIT] && !(reg_req.wr && reg_req.addr == FAULT_OFS
		&& reg_req.wdata[FLT_CABLE_BIT]) |=> fault_flags[FLT_CABLE_BIT])
		else $error("latched flag dropped without clear");

	a_wake_quiet: assert property (
		s_cmd(WAKE_CMD) ##0 !sourcing_set && !sourcing_hv_set |=> $stable(pwr_status))
		else $error("wake command changed power status");

	a_detect_off: assert property (
		s_cmd(DETECT_OFF_CMD) |=> !pwr_status.presence_monitor_on)
		else $error("monitoring still on after detect off");

	a_detect_on: assert property (
		s_cmd(DETECT_ON_CMD) |=> pwr_status.presence_monitor_on)
		else $error("monitoring off after detect on");

	a_sink_off: assert property (s_cmd(SINK_OFF_CMD) |=> !pwr_status.sinking_vbus)
		else $error("sinking still set after sink off");

	a_sink_on: assert property (
		s_cmd(SINK_ON_CMD) ##0 sink_capable |=>
		pwr_status.sinking_vbus && pwr_status.presence_monitor_on)
		else $error("sink on did not set sinking and monitoring");

	a_sink_refused: assert property (
		s_cmd(SINK_ON_CMD) ##0 !sink_capable |=> $stable(pwr_status.sinking_vbus))
		else $error("sink on acted without capability");

	a_source_off: assert property (
		s_cmd(SOURCE_OFF_CMD) |=>
		!pwr_status.sourcing_vbus && !pwr_status.sourcing_high_voltage)
		else $error("source status still set after source off");

endmodule : fscd_top

// >>> inc/fscd_pkg.sv
package fscd_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] FAULT_OFS   = 8'h1F;
	localparam logic [7:0] CMD_OFS     = 8'h23;
	localparam logic [7:0] CMD_RESET   = 8'h00;
	localparam logic [7:0] FAULT_RESET = 8'h00;

	// fault flag bit positions
	localparam int FLT_RSVD_BIT      = 7;
	localparam int FLT_FORCE_OFF_BIT = 6;
	localparam int FLT_AUTO_DIS_BIT  = 5;
	localparam int FLT_FORCE_DIS_BIT = 4;
	localparam int FLT_BUS_OCP_BIT   = 3;
	localparam int FLT_BUS_OVP_BIT   = 2;
	localparam int FLT_CABLE_BIT     = 1;
	localparam int FLT_HOST_ERR_BIT  = 0;

	// only these flags exist in hardware; the rest read as zero
	localparam logic [7:0] FAULT_LIVE_MASK = 8'h33;

	// ****************************************************************
	// command codes
	// ****************************************************************
	localparam logic [7:0] WAKE_CMD       = 8'h11;
	localparam logic [7:0] DETECT_OFF_CMD = 8'h22;
	localparam logic [7:0] DETECT_ON_CMD  = 8'h33;
	localparam logic [7:0] SINK_OFF_CMD   = 8'h44;
	localparam logic [7:0] SINK_ON_CMD    = 8'h55;
	localparam logic [7:0] SOURCE_OFF_CMD = 8'h66;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLOCK_HZ          = 10_000_000;
	localparam int DISCHARGE_TIME_US = 1000;
	localparam int DISCHARGE_CYCLES  = DISCHARGE_TIME_US * (CLOCK_HZ / 1_000_000);

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic detect_off;
		logic detect_on;
		logic sink_off;
		logic sink_on;
		logic source_off;
	} fscd_cmd_act_t;

	typedef struct packed {
		logic sourcing_high_voltage;
		logic sourcing_vbus;
		logic presence_monitor_on;
		logic sinking_vbus;
	} fscd_pwr_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fscd_reg_req_t;

endpackage : fscd_pkg

// >>> logic/fscd_cmd_decode.sv
module fscd_cmd_decode
	import fscd_pkg::*;
(
	// command write
	input  wire logic               cmd_write,
	input  wire logic [7:0]         cmd_code,
	// decoded actions
	output fscd_pkg::fscd_cmd_act_t act
);

	// one action per code; wake and unknown codes give an empty set
	always_comb begin
		act = '0;
		if (cmd_write) begin
			if (cmd_code == DETECT_OFF_CMD) begin
				act.detect_off = 1'b1;
			end else if (cmd_code == DETECT_ON_CMD) begin
				act.detect_on = 1'b1;
			end else if (cmd_code == SINK_OFF_CMD) begin
				act.sink_off = 1'b1;
			end else if (cmd_code == SINK_ON_CMD) begin
				act.sink_on = 1'b1;
			end else if (cmd_code == SOURCE_OFF_CMD) begin
				act.source_off = 1'b1;
			end else begin
				act = '0; // wake and anything else do nothing
			end
		end
	end

endmodule : fscd_cmd_decode

// >>> logic/fscd_discharge_timer.sv
module fscd_discharge_timer #(
	parameter int CYCLES = fscd_pkg::DISCHARGE_CYCLES
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// discharge control
	input  wire logic start,
	input  wire logic active,
	input  wire logic below_safe,
	// result
	output logic      fail
);
	import fscd_pkg::*;

	localparam int CW = $clog2(CYCLES);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	typedef enum logic {FSCD_IDLE, FSCD_RUN} fscd_phase_t;

	typedef struct packed {
		fscd_phase_t   phase;
		logic [CW-1:0] count;
		logic          fail;
	} fscd_tmr_t;

	fscd_tmr_t st;
	fscd_tmr_t next_st;

	// refused at elaboration: a window under two cycles leaves no counter width
	if (CYCLES < 2) begin : g_cycles_check
		$error("discharge window must be at least two cycles");
	end

	// window runs while discharge is requested and vbus is still high
	always_comb begin
		next_st = st;
		next_st.fail = 1'b0;
		case (st.phase)
			FSCD_IDLE: begin
				if (start) begin
					next_st.phase = FSCD_RUN;
					next_st.count = '0;
				end
			end
			FSCD_RUN: begin
				if (below_safe || !active) begin
					next_st.phase = FSCD_IDLE; // reached safe level or withdrawn
				end else if (st.count == LAST) begin
					next_st.fail  = 1'b1; // still high at end of window
					next_st.phase = FSCD_IDLE;
				end else begin
					next_st.count = st.count + CW'(1);
				end
			end
			default: next_st.phase = FSCD_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{phase: FSCD_IDLE, count: '0, fail: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign fail = st.fail;

	// fail only after a full window with vbus high
	a_fail_late: assert property (@(posedge clock) disable iff (!rst_n)
		fail |-> $past(st.count) == LAST && !$past(below_safe))
		else $error("discharge fail raised before window end");

endmodule : fscd_discharge_timer

// >>> sim/fscd_pm_model.sv
module fscd_pm_model
	import fscd_pkg::*;
(
	// clock
	input  wire logic               clock,
	// register bus toward the controller
	output fscd_pkg::fscd_reg_req_t reg_req,
	input  wire logic [7:0]         reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// bus idle at time zero
	initial begin
		reg_req = '0;
	end

	// released strobes drop to zero; address and data show the inverse of their last value, never a stale copy
	task automatic release_bus();
		reg_req.wr    = 1'b0;
		reg_req.rd    = 1'b0;
		reg_req.addr  = ~reg_req.addr;
		reg_req.wdata = ~reg_req.wdata;
	endtask : release_bus

	// one write strobe, taken at the next edge
	task automatic write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clock);
		#1;
		reg_req.addr  = addr;
		reg_req.wdata = (addr == FAULT_OFS) ? {1'b0, data[6:0]} : data;
		reg_req.wr    = 1'b1;
		@(posedge clock);
		#1;
		release_bus();
	endtask : write

	// read data is registered at the taking edge, so sample just after it
	task automatic read(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clock);
		#1;
		reg_req.addr = addr;
		reg_req.rd   = 1'b1;
		@(posedge clock);
		#1;
		data = reg_rdata;
		release_bus();
	endtask : read

endmodule : fscd_pm_model

// >>> sim/fscd_top_tb.sv
module fscd_top_tb;
	import fscd_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// signals
	// ****************************************************************
	// short window keeps the discharge runs brief
	localparam int DC = 8;

	logic          clock;
	logic          arst_n;
	fscd_reg_req_t reg_req;
	logic [7:0]    reg_rdata;
	logic [7:0]    fault_flags;
	fscd_pwr_t     pwr_status;
	logic          discharge_on_detach;
	logic          forced_discharge;
	logic          safe_zero_level;
	logic          cable_switch_closed;
	logic          cable_below_present;
	logic          tx_buffer_empty;
	logic          sink_capable;
	logic [4:0]    ev;
	logic [7:0]    undef_codes [5];
	int            errors;
	int            comparisons;

	// ****************************************************************
	// instances
	// ****************************************************************
	// ev pulses: detach, transmit, cable overcurrent, sourcing, sourcing hv
	fscd_top #(
		.DISCHARGE_CYCLES(DC)
	) i_fscd_top (
		.clock              (clock),
		.arst_n             (arst_n),
		.reg_req            (reg_req),
		.reg_rdata          (reg_rdata),
		.discharge_on_detach(discharge_on_detach),
		.forced_discharge   (forced_discharge),
		.detach_event       (ev[0]),
		.safe_zero_level    (safe_zero_level),
		.cable_overcurrent  (ev[2]),
		.cable_switch_closed(cable_switch_closed),
		.cable_below_present(cable_below_present),
		.tx_request         (ev[1]),
		.tx_buffer_empty    (tx_buffer_empty),
		.sink_capable       (sink_capable),
		.sourcing_set       (ev[3]),
		.sourcing_hv_set    (ev[4]),
		.pwr_status         (pwr_status),
		.fault_flags        (fault_flags)
	);

	fscd_pm_model i_fscd_pm_model (
		.clock    (clock),
		.reg_req  (reg_req),
		.reg_rdata(reg_rdata)
	);

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		i_fscd_pm_model.read(addr, d);
		chk("register read", exp, d);
	endtask : rd_chk

	// flags through the bus and on the raw port
	task automatic flags(input logic [7:0] exp);
		rd_chk(FAULT_OFS, exp);
		chk("fault port", exp, fault_flags);
	endtask : flags

	task automatic pwr(input logic [3:0] exp);
		chk("power status", {4'h0, exp}, {4'h0, pwr_status});
	endtask : pwr

	task automatic cmd(input logic [7:0] code);
		i_fscd_pm_model.write(CMD_OFS, code);
	endtask : cmd

	task automatic pulse(input int i);
		@(posedge clock);
		#1;
		ev[i] = 1'b1;
		@(posedge clock);
		#1;
		ev[i] = 1'b0;
	endtask : pulse

	// no flag while the window runs; latched right after the window's last cycle
	task automatic window(input logic [7:0] bit_mask);
		repeat (DC) @(posedge clock);
		#1;
		chk("discharge early", 8'h00, fault_flags);
		repeat (2) @(posedge clock);
		#1;
		chk("discharge late", bit_mask, fault_flags);
	endtask : window

	task automatic complete_run();
		if (errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run

	// ****************************************************************
	// clock and watchdog
	// ****************************************************************
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// tests take under 150 cycles; twenty times that means a hang
	initial begin
		repeat (3000) @(posedge clock);
		errors++;
		complete_run();
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		errors = 0;
		comparisons = 0;
		arst_n = 1'b0;
		ev = '0;
		discharge_on_detach = 1'b0;
		forced_discharge = 1'b0;
		safe_zero_level = 1'b0;
		cable_switch_closed = 1'b0;
		cable_below_present = 1'b0;
		tx_buffer_empty = 1'b1;
		sink_capable = 1'b0;
		undef_codes = '{8'h00, 8'h12, 8'h21, 8'hCC, 8'hFF};
		repeat (3) @(posedge clock);
		#1;
		arst_n = 1'b1;
		repeat (3) @(posedge clock);
		flags(FAULT_RESET);
		pwr(4'h0);
		rd_chk(CMD_OFS, CMD_RESET);
		i_fscd_pm_model.write(FAULT_OFS, 8'hFF);
		flags(8'h00);
		// host error only with an empty buffer
		tx_buffer_empty = 1'b0;
		pulse(1);
		flags(8'h00);
		tx_buffer_empty = 1'b1;
		pulse(1);
		flags(8'h01);
		i_fscd_pm_model.write(8'h40, 8'hFF);
		rd_chk(8'h40, 8'h00);
		flags(8'h01);
		i_fscd_pm_model.write(FAULT_OFS, 8'h02);
		flags(8'h01);
		i_fscd_pm_model.write(FAULT_OFS, 8'h01);
		flags(8'h00);
		pulse(1);
		flags(8'h01);
		i_fscd_pm_model.write(FAULT_OFS, 8'h01);
		// cable supply faults
		pulse(2);
		flags(8'h02);
		// a clear that meets a standing fault loses to it
		ev[2] = 1'b1;
		i_fscd_pm_model.write(FAULT_OFS, 8'h02);
		ev[2] = 1'b0;
		flags(8'h02);
		i_fscd_pm_model.write(FAULT_OFS, 8'h02);
		cable_below_present = 1'b1;
		repeat (2) @(posedge clock);
		flags(8'h00);
		cable_switch_closed = 1'b1;
		@(posedge clock);
		#1;
		cable_switch_closed = 1'b0;
		cable_below_present = 1'b0;
		flags(8'h02);
		i_fscd_pm_model.write(FAULT_OFS, 8'h02);
		// power commands; order: hv, sourcing, monitor, sinking
		cmd(SINK_ON_CMD);
		pwr(4'h0);
		sink_capable = 1'b1;
		cmd(SINK_ON_CMD);
		pwr(4'h3);
		cmd(DETECT_OFF_CMD);
		pwr(4'h1);
		cmd(DETECT_ON_CMD);
		pwr(4'h3);
		cmd(WAKE_CMD);
		pwr(4'h3);
		pulse(3);
		pulse(4);
		pwr(4'hF);
		foreach (undef_codes[i]) begin
			cmd(undef_codes[i]);
		end
		pwr(4'hF);
		flags(8'h00);
		cmd(SOURCE_OFF_CMD);
		pwr(4'h3);
		cmd(SINK_OFF_CMD);
		pwr(4'h2);
		// discharge windows
		discharge_on_detach = 1'b1;
		safe_zero_level = 1'b1;
		pulse(0);
		window(8'h00);
		safe_zero_level = 1'b0;
		pulse(0);
		window(8'h20);
		discharge_on_detach = 1'b0;
		i_fscd_pm_model.write(FAULT_OFS, 8'h20);
		flags(8'h00);
		forced_discharge = 1'b1;
		window(8'h10);
		forced_discharge = 1'b0;
		i_fscd_pm_model.write(FAULT_OFS, 8'h10);
		flags(8'h00);
		complete_run();
	end

endmodule : fscd_top_tb
